/* File: rtl/cfgdp_regs.vh */
// constants for the configuration loader and dual data pointer block
// assumes inclusion by bare name from rtl files
`ifndef CFGDP_REGS_VH
`define CFGDP_REGS_VH
`define CFGDP_SIG0_ADDR 16'hFC30
`define CFGDP_SIG1_ADDR 16'hFC31
`define CFGDP_SIG2_ADDR 16'hFC60
`define CFGDP_USER_BASE 16'hFCE0
`define CFGDP_USER_LAST 16'hFCFF
`define CFGDP_CFG1_ADDR 16'hFD00
`define CFGDP_CFG2_ADDR 16'hFD01
`define CFGDP_CFG_RESET 8'hFF
`define CFGDP_AUX_RESET 8'h00
`define CFGDP_AUX_SEL_BIT 0
`define CFGDP_AUX_ZERO_BIT 2
`define CFGDP_C1_WDT_BIT 7
`define CFGDP_C1_RPD_BIT 6
`define CFGDP_C1_PRL_BIT 5
`define CFGDP_C1_BOV_BIT 4
`define CFGDP_C1_CLK_BIT 3
`define CFGDP_C2_SB2_BIT 7
`define CFGDP_C2_SB1_BIT 6
`define CFGDP_OSC_EXT 3'b111
`define CFGDP_OSC_RC 3'b011
`define CFGDP_OSC_LOW 3'b010
`define CFGDP_OSC_MED 3'b001
`define CFGDP_OSC_HIGH 3'b000
`endif

/* File: rtl/cfgdp_pointer.v */
// one 16-bit data pointer with byte writes and increment
// assumes the caller gates enables with the pointer select
`timescale 1ns/1ps
module cfgdp_pointer #(
    parameter WIDTH = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire wr_lo,
    input wire wr_hi,
    input wire load,
    input wire inc,
    input wire [7:0] wdata,
    input wire [WIDTH-1:0] load_val,
    output reg [WIDTH-1:0] ptr_ff
);
    reg [WIDTH-1:0] nxt_ptr;
    always @* begin
        nxt_ptr = ptr_ff;
        if (load)
            nxt_ptr = load_val;
        else if (inc)
            nxt_ptr = ptr_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        else if (wr_hi)
            nxt_ptr = {wdata, ptr_ff[7:0]};
        else if (wr_lo)
            nxt_ptr = {ptr_ff[WIDTH-1:8], wdata};
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            ptr_ff <= {WIDTH{1'b0}};
        else
            ptr_ff <= nxt_ptr;
    end
endmodule

/* File: rtl/cfgdp_top.v */
// configuration byte loader, security gate, signature and dual data pointer
// assumes nonvolatile bytes sit on nv_* ports, cpu strobes are mclk-synchronous
`timescale 1ns/1ps
`include "cfgdp_regs.vh"
module cfgdp_top #(
    parameter PTR_W = 16,
    parameter [7:0] SIG0 = 8'h5A,
    parameter [7:0] SIG1 = 8'hA5,
    parameter [7:0] SIG2 = 8'h3C
) (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] nv_cfg1,
    input wire [7:0] nv_cfg2,
    input wire aux_wr,
    input wire aux_inc,
    input wire [7:0] aux_wdata,
    input wire dph_wr,
    input wire dpl_wr,
    input wire [7:0] sfr_wdata,
    input wire ptr_load,
    input wire [15:0] ptr_load_val,
    input wire ptr_inc,
    input wire code_rd,
    input wire [7:0] acc_off,
    input wire data_rd,
    input wire [7:0] user_rdata,
    input wire pgm_req,
    input wire pgm_sb2_req,
    input wire vfy_req,
    input wire wd_run_sw,
    input wire wd_clk_sw,
    output reg [7:0] aux_rdata_ff,
    output reg [7:0] dph_rdata_ff,
    output reg [7:0] dpl_rdata_ff,
    output reg [15:0] ptr_addr_ff,
    output reg [7:0] rd_data_ff,
    output reg rd_valid_ff,
    output reg [7:0] user_addr_ff,
    output reg user_rd_ff,
    output reg pgm_ok_ff,
    output reg vfy_ok_ff,
    output reg watchdog_reset_enable_ff,
    output reg watchdog_run_control_ff,
    output reg watchdog_clock_select_ff,
    output reg reset_pin_disable_ff,
    output reg port_reset_level_ff,
    output reg brownout_threshold_select_ff,
    output reg clock_divide_select_ff,
    output reg [2:0] oscillator_type_ff,
    output reg osc_reserved_ff
);
    // loader: grabs nv bytes in the first cycle after reset release
    reg load_done_ff;
    reg [7:0] cfg1_ff;
    reg [7:0] cfg2_ff;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            load_done_ff <= 1'b0;
            cfg1_ff <= `CFGDP_CFG_RESET;
            cfg2_ff <= `CFGDP_CFG_RESET;
        end else if (!load_done_ff) begin
            // no software path ever writes these
            cfg1_ff <= nv_cfg1;
            cfg2_ff <= nv_cfg2;
            load_done_ff <= 1'b1;
        end
    end

    // auxiliary control, select bit at 0
    reg [7:0] aux_ff;
    reg [7:0] nxt_aux;
    always @* begin
        nxt_aux = aux_ff;
        if (aux_wr)
            nxt_aux = aux_wdata;
        else if (aux_inc)
            nxt_aux = aux_ff + 8'h01;
        nxt_aux[`CFGDP_AUX_ZERO_BIT] = 1'b0;
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            aux_ff <= `CFGDP_AUX_RESET;
        else
            aux_ff <= nxt_aux;
    end
    wire pointer_select = aux_ff[`CFGDP_AUX_SEL_BIT];

    // two pointers; enables gated by select
    wire [PTR_W-1:0] ptr0;
    wire [PTR_W-1:0] ptr1;
    cfgdp_pointer #(.WIDTH(PTR_W)) u_ptr0 (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_lo(dpl_wr & ~pointer_select),
        .wr_hi(dph_wr & ~pointer_select),
        .load(ptr_load & ~pointer_select),
        .inc(ptr_inc & ~pointer_select),
        .wdata(sfr_wdata),
        .load_val(ptr_load_val[PTR_W-1:0]),
        .ptr_ff(ptr0)
    );
    cfgdp_pointer #(.WIDTH(PTR_W)) u_ptr1 (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_lo(dpl_wr & pointer_select),
        .wr_hi(dph_wr & pointer_select),
        .load(ptr_load & pointer_select),
        .inc(ptr_inc & pointer_select),
        .wdata(sfr_wdata),
        .load_val(ptr_load_val[PTR_W-1:0]),
        .ptr_ff(ptr1)
    );
    wire [PTR_W-1:0] data_pointer = pointer_select ? ptr1 : ptr0;

    // code and data reads through the selected pointer
    wire [15:0] code_addr = data_pointer + {8'h00, acc_off};
    wire in_user = (code_addr >= `CFGDP_USER_BASE) && (code_addr <= `CFGDP_USER_LAST);
    reg [7:0] nxt_rd;
    reg nxt_valid;
    always @* begin
        nxt_rd = 8'h00;
        nxt_valid = 1'b0;
        if (code_rd) begin
            nxt_valid = 1'b1;
            case (code_addr)
                `CFGDP_SIG0_ADDR: nxt_rd = SIG0;
                `CFGDP_SIG1_ADDR: nxt_rd = SIG1;
                `CFGDP_SIG2_ADDR: nxt_rd = SIG2;
                default: nxt_rd = 8'h00;
            endcase
        end else if (data_rd) begin
            nxt_valid = 1'b1;
            case (data_pointer)
                `CFGDP_CFG1_ADDR: nxt_rd = cfg1_ff;
                `CFGDP_CFG2_ADDR: nxt_rd = cfg2_ff;
                default: nxt_rd = 8'h00;
            endcase
        end
    end

    // user area data arrives one cycle later from the array
    reg user_pend_ff;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
            user_rd_ff <= 1'b0;
            user_addr_ff <= 8'h00;
            user_pend_ff <= 1'b0;
        end else begin
            user_rd_ff <= code_rd & in_user;
            user_addr_ff <= code_addr[7:0];
            user_pend_ff <= code_rd & in_user;
            if (user_pend_ff) begin
                rd_data_ff <= user_rdata;
                rd_valid_ff <= 1'b1;
            end else begin
                rd_data_ff <= nxt_rd;
                rd_valid_ff <= nxt_valid & ~(code_rd & in_user);
            end
        end
    end

    // security: sb2 at 7, sb1 at 6
    wire sb2 = cfg2_ff[`CFGDP_C2_SB2_BIT];
    wire sb1 = cfg2_ff[`CFGDP_C2_SB1_BIT];
    reg nxt_pgm;
    reg nxt_vfy;
    always @* begin
        case ({sb2, sb1})
            2'b11: begin
                nxt_pgm = pgm_req | pgm_sb2_req;
                nxt_vfy = vfy_req;
            end
            2'b10: begin
                nxt_pgm = pgm_sb2_req;
                nxt_vfy = vfy_req;
            end
            2'b00: begin
                nxt_pgm = 1'b0;
                nxt_vfy = 1'b0;
            end
            // unsupported combination, treated as locked
            default: begin
                nxt_pgm = 1'b0;
                nxt_vfy = 1'b0;
            end
        endcase
    end

    // feature controls from held bytes
    wire [2:0] osc = cfg1_ff[2:0];
    reg osc_res;
    always @* begin
        case (osc)
            `CFGDP_OSC_EXT, `CFGDP_OSC_RC, `CFGDP_OSC_LOW,
            `CFGDP_OSC_MED, `CFGDP_OSC_HIGH: osc_res = 1'b0;
            default: osc_res = 1'b1;
        endcase
    end
    wire watchdog_reset_enable = cfg1_ff[`CFGDP_C1_WDT_BIT];
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pgm_ok_ff <= 1'b0;
            vfy_ok_ff <= 1'b0;
            watchdog_reset_enable_ff <= 1'b1;
            watchdog_run_control_ff <= 1'b1;
            watchdog_clock_select_ff <= 1'b0;
            reset_pin_disable_ff <= 1'b0;
            port_reset_level_ff <= 1'b1;
            brownout_threshold_select_ff <= 1'b1;
            clock_divide_select_ff <= 1'b0;
            oscillator_type_ff <= `CFGDP_OSC_EXT;
            osc_reserved_ff <= 1'b0;
            aux_rdata_ff <= 8'h00;
            dph_rdata_ff <= 8'h00;
            dpl_rdata_ff <= 8'h00;
            ptr_addr_ff <= 16'h0000;
        end else begin
            pgm_ok_ff <= nxt_pgm & load_done_ff;
            vfy_ok_ff <= nxt_vfy & load_done_ff;
            watchdog_reset_enable_ff <= watchdog_reset_enable;
            watchdog_run_control_ff <= watchdog_reset_enable | wd_run_sw;
            watchdog_clock_select_ff <= ~watchdog_reset_enable & wd_clk_sw;
            reset_pin_disable_ff <= ~cfg1_ff[`CFGDP_C1_RPD_BIT];
            port_reset_level_ff <= cfg1_ff[`CFGDP_C1_PRL_BIT];
            brownout_threshold_select_ff <= cfg1_ff[`CFGDP_C1_BOV_BIT];
            clock_divide_select_ff <= ~cfg1_ff[`CFGDP_C1_CLK_BIT];
            oscillator_type_ff <= osc;
            osc_reserved_ff <= osc_res;
            aux_rdata_ff <= aux_ff;
            dph_rdata_ff <= data_pointer[15:8];
            dpl_rdata_ff <= data_pointer[7:0];
            ptr_addr_ff <= data_pointer;
        end
    end
    // serial programming pins live in the programming controller, not here
endmodule

/* File: verif/cfgdp_monitor.sv */
// checker for config outputs, security gate and read answers
// assumes bind onto cfgdp_top; config bytes change only in reset
`timescale 1ns/1ps
module cfgdp_monitor (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] nv_cfg1,
    input wire [7:0] nv_cfg2,
    input wire data_rd,
    input wire rd_valid_ff,
    input wire pgm_ok_ff,
    input wire vfy_ok_ff,
    input wire watchdog_reset_enable_ff,
    input wire watchdog_run_control_ff,
    input wire watchdog_clock_select_ff,
    input wire reset_pin_disable_ff,
    input wire port_reset_level_ff,
    input wire brownout_threshold_select_ff,
    input wire clock_divide_select_ff,
    input wire [2:0] oscillator_type_ff,
    input wire osc_reserved_ff
);
    // outputs settle two edges after release; wait three for margin
    reg [1:0] age_ff;
    wire ok = age_ff == 2'h3;
    wire [7:0] c = nv_cfg1;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            age_ff <= 2'h0;
        else if (!ok)
            age_ff <= age_ff + 2'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_wdt_follows: assert property (ok |-> watchdog_reset_enable_ff == c[7])
        else $error("watchdog enable wrong");
    a_wdt_forces: assert property (watchdog_reset_enable_ff |->
        watchdog_run_control_ff && !watchdog_clock_select_ff) else $error("watchdog not forced");
    a_pin_input: assert property (ok |-> reset_pin_disable_ff == !c[6])
        else $error("reset pin use wrong");
    a_port_level: assert property (ok |-> port_reset_level_ff == c[5])
        else $error("port reset level wrong");
    a_bov_sel: assert property (ok |-> brownout_threshold_select_ff == c[4])
        else $error("brownout select wrong");
    a_clk_div: assert property (ok |-> clock_divide_select_ff == !c[3])
        else $error("clock divide wrong");
    a_osc_type: assert property (ok |-> oscillator_type_ff == c[2:0] &&
        osc_reserved_ff == (c[2] && !(c[1] && c[0]))) else $error("oscillator code wrong");
    a_full_lock: assert property (ok && !nv_cfg2[7] |-> !pgm_ok_ff && !vfy_ok_ff)
        else $error("locked part allowed access");
    a_read_ans: assert property (data_rd |=> rd_valid_ff)
        else $error("data read unanswered");
    cover property (rd_valid_ff);
    cover property (pgm_ok_ff);
    cover property (ok && osc_reserved_ff);
endmodule
bind cfgdp_top cfgdp_monitor u_mon (.*);

/* File: verif/cfgdp_user_mem.sv */
// behavioural user information array on the fetch port
// assumes strobe and address come registered from cfgdp_top
`timescale 1ns/1ps
module cfgdp_user_mem (
    input wire mclk,
    input wire user_rd_ff,
    input wire [7:0] user_addr_ff,
    output reg [7:0] user_rdata
);
    reg hold_ff = 1'b0;
    initial user_rdata = 8'h00;
    // data set one half-cycle before the sampling edge, held three half-cycles after; idle flips so stale never matches
    always @(negedge mclk) begin
        hold_ff <= user_rd_ff;
        if (user_rd_ff)
            user_rdata <= 8'ha0 | {3'h0, user_addr_ff[4:0]};
        else if (!hold_ff)
            user_rdata <= ~user_rdata;
    end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the config loader and dual pointers
// assumes cfgdp_top, cfgdp_user_mem and the bound checker
`timescale 1ns/1ps
module tb;
    localparam [7:0] SIG0 = 8'h11; // arbitrary signature values
    localparam [7:0] SIG1 = 8'h22;
    localparam [7:0] SIG2 = 8'h33;
    localparam [47:0] CFGS = 48'h7ba2_5108_fdff;
    reg mclk, rst_n, aux_wr, aux_inc, dph_wr, dpl_wr, ptr_load, ptr_inc, code_rd, data_rd;
    reg pgm_req, pgm_sb2_req, vfy_req, wd_run_sw, wd_clk_sw;
    reg [7:0] nv_cfg1, nv_cfg2, aux_wdata, sfr_wdata, acc_off, c;
    reg [15:0] ptr_load_val;
    wire [7:0] aux_rdata_ff, dph_rdata_ff, dpl_rdata_ff, rd_data_ff, user_addr_ff, user_rdata;
    wire [15:0] ptr_addr_ff;
    wire [2:0] oscillator_type_ff;
    wire rd_valid_ff, user_rd_ff, pgm_ok_ff, vfy_ok_ff, watchdog_reset_enable_ff;
    wire watchdog_run_control_ff, watchdog_clock_select_ff, reset_pin_disable_ff;
    wire port_reset_level_ff, brownout_threshold_select_ff, clock_divide_select_ff;
    wire osc_reserved_ff;
    integer errors, check_count, i;
    cfgdp_top #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2)) uut (.*);
    cfgdp_user_mem u_mem (.*);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task tick(input integer n);
        repeat (n) @(negedge mclk);
    endtask
    task chk(input [39:0] nm, input [15:0] exp, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[FAIL] %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task boot(input [7:0] c1, input [7:0] c2);
        begin
            rst_n = 1'b0;
            nv_cfg1 = c1;
            nv_cfg2 = c2;
            tick(3);
            rst_n = 1'b1;
            tick(3);
        end
    endtask
    task ld(input [15:0] v);
        begin
            ptr_load_val = v;
            ptr_load = 1'b1;
            tick(1);
            ptr_load = 1'b0;
            tick(2);
        end
    endtask
    task rd(input code, input [7:0] off, input [7:0] exp);
        begin
            code_rd = code;
            data_rd = !code;
            acc_off = off;
            tick(1);
            code_rd = 1'b0;
            data_rd = 1'b0;
            repeat (4) if (rd_valid_ff !== 1'b1) tick(1);
            chk("vld", 16'h0001, {15'h0, rd_valid_ff});
            chk("rd", {8'h00, exp}, {8'h00, rd_data_ff});
            tick(2);
        end
    endtask
    task t_ptr;
        begin
            chk("aux", 16'h0000, {8'h00, aux_rdata_ff});
            ld(16'hfc30);
            rd(1'b1, 8'h00, SIG0);
            rd(1'b1, 8'h01, SIG1);
            rd(1'b1, 8'h30, SIG2);
            rd(1'b1, 8'hb0, 8'ha0);
            rd(1'b1, 8'hcf, 8'hbf);
            rd(1'b0, 8'h00, 8'h00);
            aux_inc = 1'b1;
            tick(1);
            aux_inc = 1'b0;
            ld(16'h12fe);
            ptr_inc = 1'b1;
            sfr_wdata = 8'hfd;
            tick(1);
            ptr_inc = 1'b0;
            dph_wr = 1'b1;
            tick(1);
            dph_wr = 1'b0;
            tick(2);
            chk("ptr1", 16'hfdff, ptr_addr_ff);
            chk("dph", 16'h00fd, {8'h00, dph_rdata_ff});
            aux_inc = 1'b1;
            tick(1);
            aux_inc = 1'b0;
            tick(2);
            chk("ptr0", 16'hfc30, ptr_addr_ff);
            aux_wdata = 8'h05;
            aux_wr = 1'b1;
            tick(1);
            aux_wr = 1'b0;
            tick(2);
            chk("auxb", 16'h0001, {14'h0, aux_rdata_ff[2], aux_rdata_ff[0]});
            chk("ptr1b", 16'hfdff, ptr_addr_ff);
            sfr_wdata = 8'h5c;
            dpl_wr = 1'b1;
            tick(1);
            dpl_wr = 1'b0;
            tick(2);
            chk("dpl", 16'h005c, {8'h00, dpl_rdata_ff});
            chk("ptr1c", 16'hfd5c, ptr_addr_ff);
        end
    endtask
    task t_cfg;
        for (i = 0; i < 6; i = i + 1) begin
            c = CFGS[8*i +: 8];
            boot(c, 8'hff);
            chk("osc", {13'h0, c[2:0]}, {13'h0, oscillator_type_ff});
            chk("wd", {14'h0, c[7], !c[7]}, {14'h0, watchdog_run_control_ff,
                watchdog_clock_select_ff});
            chk("cfg", {11'h0, c[7], !c[6], c[5], c[4], !c[3]}, {11'h0, watchdog_reset_enable_ff,
                reset_pin_disable_ff, port_reset_level_ff, brownout_threshold_select_ff,
                clock_divide_select_ff});
            {wd_run_sw, wd_clk_sw} = 2'b10;
            tick(2);
            chk("wdsw", 16'h0002, {14'h0, watchdog_run_control_ff,
                watchdog_clock_select_ff});
            {wd_run_sw, wd_clk_sw} = 2'b01;
            ld(16'hfd00);
            rd(1'b0, 8'h00, c);
        end
    endtask
    task t_sec;
        for (i = 0; i < 4; i = i + 1) if (i != 1) begin
            boot(8'hff, {i[1:0], 6'h3f});
            pgm_req = 1'b1;
            vfy_req = 1'b1;
            tick(3);
            chk("sec", {14'h0, i == 3, i[1]}, {14'h0, pgm_ok_ff, vfy_ok_ff});
            pgm_req = 1'b0;
            pgm_sb2_req = 1'b1;
            tick(3);
            chk("sb2", {15'h0, i[1]}, {15'h0, pgm_ok_ff});
            {pgm_sb2_req, vfy_req} = 2'h0;
            ld(16'hfd01);
            rd(1'b0, 8'h00, {i[1:0], 6'h3f});
        end
    endtask
    task close_out;
        begin
            $display("checks %0d errors %0d", check_count, errors);
            if (errors == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #20000;
        errors = errors + 1;
        close_out;
    end
    initial begin
        errors = 0;
        check_count = 0;
        {aux_wr, aux_inc, dph_wr, dpl_wr, ptr_load, ptr_inc, code_rd, data_rd} = 8'h00;
        {pgm_req, pgm_sb2_req, vfy_req, wd_run_sw, wd_clk_sw} = 5'h01;
        {aux_wdata, sfr_wdata, acc_off, ptr_load_val} = 40'h0;
        boot(8'hff, 8'hff);
        t_ptr;
        t_cfg;
        t_sec;
        close_out;
    end
endmodule
